//--- rscl_consts.svh
// constants for the run/stop command latch
`ifndef RSCL_CONSTS_SVH
`define RSCL_CONSTS_SVH

// terminal function selection codes
`define RSCL_FN_LOW_SPEED     16'h0000
`define RSCL_FN_MID_SPEED     16'h0001
`define RSCL_FN_HIGH_SPEED    16'h0002
`define RSCL_FN_HOLD_RELEASE  16'h0019
`define RSCL_FN_KEEP_REV      16'h270F

// number of assignable terminals: four general plus the reverse-run one
`define RSCL_NUM_TERMS        5
`define RSCL_REV_TERM         4

// reset values
`define RSCL_SPEED_RST        16'h0000

// synchroniser depth for pin inputs
`define RSCL_SYNC_STAGES      3

`endif

//--- rscl_pkg.sv
// types for the run/stop command latch
package rscl_pkg;

  // run state of the command latch
  typedef enum logic [1:0] {
    RSCL_IDLE,
    RSCL_RUN_FWD,
    RSCL_RUN_REV
  } rscl_state_e;

  typedef logic [15:0] rscl_code_t;
  typedef logic [15:0] rscl_speed_t;

endpackage

//--- rscl_pins_if.sv
// carrier between the latch and its pin conditioner
`timescale 1ns/1ps

interface rscl_pins_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;

  modport cond (input raw, output clean);
  modport user (output raw, input clean);
endinterface

//--- rscl_pin_cond.sv
// three-stage synchroniser and agree filter for contact pins
`timescale 1ns/1ps

module rscl_pin_cond #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pins in, conditioned levels out
  rscl_pins_if.cond pins
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  initial begin
    if (WIDTH < 1) begin
      $error("rscl_pin_cond: WIDTH must be at least 1");
    end
  end

  // a change counts only once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
    end
  end

  // synchroniser chain and filtered level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign pins.clean = level;

endmodule

//--- rscl_run_latch.sv
// start/stop command latch with two-wire and self-holding modes
`timescale 1ns/1ps
`include "rscl_consts.svh"

// Functional notes
// - single run input starts matching direction
// - two-wire: both or removed input stops
// - hold-release active enables self-holding
// - self-holding: run inputs only start
// - self-holding: run pulse latches run request
// - hold-release opened clears latch, stops
// - jog active ignores hold-release, has priority
// - output inhibit keeps self-holding state
// - speed from jog, three presets or analog
// - keep-reverse code valid only on reverse terminal
module rscl_run_latch #(
  parameter int SPEED_W = 16
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // contact pins, closed to contact_common is high
  input  wire logic                 fwd_run_input,
  input  wire logic                 rev_run_input,
  input  wire logic [3:0]           assign_terminal,
  input  wire logic                 inch_run_input,
  input  wire logic                 output_inhibit,
  // terminal function selections
  input  wire logic [15:0]          term_sel_0,
  input  wire logic [15:0]          term_sel_1,
  input  wire logic [15:0]          term_sel_2,
  input  wire logic [15:0]          term_sel_3,
  input  wire logic [15:0]          term_sel_rev,
  // speed sources
  input  wire logic [SPEED_W-1:0]   analog_speed,
  input  wire logic [SPEED_W-1:0]   preset_high,
  input  wire logic [SPEED_W-1:0]   preset_mid,
  input  wire logic [SPEED_W-1:0]   preset_low,
  input  wire logic [SPEED_W-1:0]   inch_speed,
  // drive commands and status
  output logic                      run_cmd,
  output logic                      run_reverse,
  output logic                      drive_enable,
  output logic                      decel_stop,
  output logic                      self_hold_mode,
  output logic                      config_error,
  output logic [SPEED_W-1:0]        speed_ref
);

  localparam int NPINS = `RSCL_NUM_TERMS + 3;

  initial begin
    if (SPEED_W < 1 || SPEED_W > 16) begin
      $error("rscl_run_latch: SPEED_W must be 1 to 16");
    end
  end

  // pin conditioning
  rscl_pins_if #(.WIDTH(NPINS)) pins ();

  rscl_pin_cond #(.WIDTH(NPINS)) i_rscl_pin_cond (
    .clk  (clk),
    .rst  (rst),
    .pins (pins)
  );

  assign pins.raw = {output_inhibit, inch_run_input, fwd_run_input,
                     rev_run_input, assign_terminal};

  logic                     term [`RSCL_NUM_TERMS];
  rscl_pkg::rscl_code_t     sel  [`RSCL_NUM_TERMS];
  logic                     fwd_lvl;
  logic                     inch_lvl;
  logic                     inhibit_lvl;

  assign term[0]     = pins.clean[0];
  assign term[1]     = pins.clean[1];
  assign term[2]     = pins.clean[2];
  assign term[3]     = pins.clean[3];
  assign term[4]     = pins.clean[4];
  assign fwd_lvl     = pins.clean[5];
  assign inch_lvl    = pins.clean[6];
  assign inhibit_lvl = pins.clean[7];
  assign sel[0]      = term_sel_0;
  assign sel[1]      = term_sel_1;
  assign sel[2]      = term_sel_2;
  assign sel[3]      = term_sel_3;
  assign sel[4]      = term_sel_rev;

  // legal function codes for an assignable terminal
  function automatic logic code_ok(input rscl_pkg::rscl_code_t c, input logic is_rev);
    logic ok;
    ok = (c <= 16'h0003) || (c == 16'h0005) ||
         (c >= 16'h0008 && c <= 16'h0010) || (c == 16'h0014) ||
         (c >= 16'h0016 && c <= 16'h001C) ||
         (c >= 16'h002A && c <= 16'h002C);
    // keep-reverse code only on the reverse terminal
    if (c == `RSCL_FN_KEEP_REV) begin
      ok = is_rev;
    end
    return ok;
  endfunction

  // terminal routing: hold-release, presets, reverse run
  logic hold_assigned;
  logic hold_lvl;
  logic sp_high;
  logic sp_mid;
  logic sp_low;
  logic rev_lvl;
  logic cfg_bad;

  always_comb begin
    hold_assigned = 1'b0;
    hold_lvl      = 1'b0;
    sp_high       = 1'b0;
    sp_mid        = 1'b0;
    sp_low        = 1'b0;
    cfg_bad       = 1'b0;
    for (int i = 0; i < `RSCL_NUM_TERMS; i++) begin
      if (code_ok(sel[i], i == `RSCL_REV_TERM)) begin
        if (sel[i] == `RSCL_FN_HOLD_RELEASE) begin
          hold_assigned = 1'b1;
          hold_lvl      = hold_lvl | term[i];
        end
        if (sel[i] == `RSCL_FN_HIGH_SPEED) begin
          sp_high = sp_high | term[i];
        end
        if (sel[i] == `RSCL_FN_MID_SPEED) begin
          sp_mid = sp_mid | term[i];
        end
        if (sel[i] == `RSCL_FN_LOW_SPEED) begin
          sp_low = sp_low | term[i];
        end
      end else begin
        cfg_bad = 1'b1;
      end
    end
    rev_lvl = (term_sel_rev == `RSCL_FN_KEEP_REV) && term[`RSCL_REV_TERM];
  end

  // previous levels for edge detection
  logic fwd_prev;
  logic rev_prev;
  logic next_fwd_prev;
  logic next_rev_prev;

  assign next_fwd_prev = fwd_lvl;
  assign next_rev_prev = rev_lvl;

  // run state machine
  rscl_pkg::rscl_state_e state;
  rscl_pkg::rscl_state_e next_state;
  logic                  hold_mode;
  logic                  next_decel;
  logic                  decel_q;

  // no hold-release terminal keeps two-wire
  // self_hold_mode reports hold_mode only while the release contact is closed
  assign hold_mode = hold_assigned && !inch_lvl;

  always_comb begin
    next_state = state;
    if (!hold_mode) begin
      // one input alone runs that way
      if (fwd_lvl && !rev_lvl) begin
        next_state = rscl_pkg::RSCL_RUN_FWD;
      end else if (rev_lvl && !fwd_lvl) begin
        next_state = rscl_pkg::RSCL_RUN_REV;
      end else begin
        next_state = rscl_pkg::RSCL_IDLE;
      end
    end else if (!hold_lvl) begin
      next_state = rscl_pkg::RSCL_IDLE;
    end else begin
      // run inputs act as start only
      // a press latches the run request
      if (fwd_lvl && !fwd_prev) begin
        next_state = rscl_pkg::RSCL_RUN_FWD;
      end else if (rev_lvl && !rev_prev) begin
        next_state = rscl_pkg::RSCL_RUN_REV;
      end
    end
    next_decel = (state != rscl_pkg::RSCL_IDLE) && (next_state == rscl_pkg::RSCL_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= rscl_pkg::RSCL_IDLE;
      fwd_prev <= 1'b0;
      rev_prev <= 1'b0;
      decel_q  <= 1'b0;
    end else begin
      state    <= next_state;
      fwd_prev <= next_fwd_prev;
      rev_prev <= next_rev_prev;
      decel_q  <= next_decel;
    end
  end

  // speed reference select: jog, presets, then analog
  logic [SPEED_W-1:0] speed_q;
  logic [SPEED_W-1:0] next_speed;

  always_comb begin
    // preset speeds override the analog input
    if (inch_lvl) begin
      next_speed = inch_speed;
    end else if (sp_high) begin
      next_speed = preset_high;
    end else if (sp_mid) begin
      next_speed = preset_mid;
    end else if (sp_low) begin
      next_speed = preset_low;
    end else begin
      next_speed = analog_speed;
    end
  end

  // registered outputs
  logic run_q;
  logic rev_q;
  logic enable_q;
  logic hold_q;
  logic err_q;
  logic next_enable;

  // inhibit gates the output only, not the latch
  assign next_enable = (next_state != rscl_pkg::RSCL_IDLE) && !inhibit_lvl;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_q  <= SPEED_W'(`RSCL_SPEED_RST);
      run_q    <= 1'b0;
      rev_q    <= 1'b0;
      enable_q <= 1'b0;
      hold_q   <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      speed_q  <= next_speed;
      run_q    <= next_state != rscl_pkg::RSCL_IDLE;
      rev_q    <= next_state == rscl_pkg::RSCL_RUN_REV;
      enable_q <= next_enable;
      hold_q   <= hold_mode && hold_lvl;
      err_q    <= cfg_bad;
    end
  end

  assign run_cmd        = run_q;
  assign run_reverse    = rev_q;
  assign drive_enable   = enable_q;
  assign decel_stop     = decel_q;
  assign self_hold_mode = hold_q;
  assign config_error   = err_q;
  assign speed_ref      = speed_q;

endmodule

//--- rscl_run_latch_sva.sv
// checker for the run/stop command latch
`timescale 1ns/1ps
`include "rscl_consts.svh"

module rscl_run_latch_chk (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // contact pins and selection
  input  wire logic        fwd_run_input,
  input  wire logic        rev_run_input,
  input  wire logic [3:0]  assign_terminal,
  input  wire logic        inch_run_input,
  input  wire logic        output_inhibit,
  input  wire logic [15:0] term_sel_0,
  // drive outputs
  input  wire logic        run_cmd,
  input  wire logic        drive_enable,
  input  wire logic        decel_stop,
  input  wire logic        self_hold_mode,
  input  wire logic        config_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_start;
    $rose(fwd_run_input) && !rev_run_input && !run_cmd |-> ##[4:6] run_cmd;
  endproperty
  a_start: assert property (p_start) else $error("run not started");

  property p_stop;
    !self_hold_mode && run_cmd && $fell(fwd_run_input) && !rev_run_input |-> ##[4:6] !run_cmd;
  endproperty
  a_stop: assert property (p_stop) else $error("run not stopped");

  property p_decel;
    $fell(run_cmd) |-> decel_stop ##1 !decel_stop;
  endproperty
  a_decel: assert property (p_decel) else $error("stop pulse wrong");

  property p_latch;
    self_hold_mode && !run_cmd && $rose(fwd_run_input) |-> ##[4:6] run_cmd ##1 run_cmd [*8];
  endproperty
  a_latch: assert property (p_latch) else $error("run not latched");

  property p_release;
    self_hold_mode && $fell(assign_terminal[0]) && !inch_run_input
      && term_sel_0 == `RSCL_FN_HOLD_RELEASE |-> ##[4:6] !run_cmd && !self_hold_mode;
  endproperty
  a_release: assert property (p_release) else $error("release ignored");

  property p_jog;
    inch_run_input && fwd_run_input && run_cmd && $fell(assign_terminal[0]) |=> run_cmd [*8];
  endproperty
  a_jog: assert property (p_jog) else $error("jog lost run");

  property p_inhibit;
    run_cmd && $rose(output_inhibit) |-> ##[4:6] run_cmd && !drive_enable;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit wrong");

  property p_cfg;
    term_sel_0 == `RSCL_FN_KEEP_REV |-> ##[1:6] config_error;
  endproperty
  a_cfg: assert property (p_cfg) else $error("bad code accepted");
endmodule

//--- rscl_contacts.sv
// contact switches of the external controller
`timescale 1ns/1ps

module rscl_contacts (
  // clock
  input  wire logic       clk,
  // terms 3:0, fwd, rev, jog, inhibit
  output logic      [7:0] pins
);
  initial pins = '0;

  // set masked contacts to levels
  task automatic drive(input logic [7:0] m, input logic [7:0] v);
    @(negedge clk);
    pins = (pins & ~m) | (v & m);
  endtask

  task automatic pulse(input logic [7:0] m);
    drive(m, m);
    repeat (4) @(negedge clk);
    drive(m, 8'h00);
  endtask
endmodule

//--- test_rscl_run_latch.sv
// self-checking bench for the run/stop command latch
`timescale 1ns/1ps

module test_rscl_run_latch;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  pins;
  logic [15:0] sel [5];
  logic [15:0] spd [5];
  logic        run_cmd, run_reverse, drive_enable, decel_stop, self_hold_mode, config_error;
  logic [15:0] speed_ref;
  logic [22:0] q [$];
  logic [5:0]  last = '0;
  int          n_mismatch = 0;
  int          n_tests = 0;

  rscl_contacts i_rscl_contacts (.clk, .pins);
  rscl_run_latch i_rscl_run_latch (
    .clk, .rst, .fwd_run_input(pins[4]), .rev_run_input(pins[5]),
    .assign_terminal(pins[3:0]), .inch_run_input(pins[6]), .output_inhibit(pins[7]),
    .term_sel_0(sel[0]), .term_sel_1(sel[1]), .term_sel_2(sel[2]), .term_sel_3(sel[3]),
    .term_sel_rev(sel[4]), .analog_speed(spd[0]), .preset_high(spd[1]),
    .preset_mid(spd[2]), .preset_low(spd[3]), .inch_speed(spd[4]),
    .run_cmd, .run_reverse, .drive_enable, .decel_stop, .self_hold_mode,
    .config_error, .speed_ref
  );

  initial forever #5 clk = ~clk;

  // note one expected output change
  task automatic note(input logic [5:0] v, input logic [15:0] s);
    q.push_back({v[3], v, s});
  endtask

  // compare one output change
  task automatic chk(input logic [22:0] e);
    n_tests++;
    if (last !== e[21:16] || (e[22] && speed_ref !== e[15:0])) begin
      n_mismatch++;
      $display("unexpected outputs: expected %h seen %h speed %h", e, last, speed_ref);
    end
  endtask

  task automatic step(input logic [7:0] m, input logic [7:0] v);
    i_rscl_contacts.drive(m, v);
    repeat (12) @(negedge clk);
  endtask

  task automatic pls(input logic [7:0] m);
    i_rscl_contacts.pulse(m);
    repeat (12) @(negedge clk);
  endtask

  task automatic setsel(input logic [15:0] v);
    @(negedge clk) sel[0] = v;
    repeat (12) @(negedge clk);
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watch outputs, pop a note on each change
  always @(negedge clk) begin
    if ({config_error, self_hold_mode, run_cmd, run_reverse, drive_enable, decel_stop}
        !== last) begin
      last = {config_error, self_hold_mode, run_cmd, run_reverse, drive_enable, decel_stop};
      chk(q.size() ? q.pop_front() : 23'h7FFFFF);
    end
  end

  // watchdog against a hang
  initial begin
    #20us;
    n_mismatch++;
    $display("unexpected timeout: expected done seen running");
    complete_run();
  end

  initial begin
    void'($urandom(88));
    foreach (spd[i]) spd[i] = 16'($urandom);
    sel = '{16'h0003, 16'h0000, 16'h0001, 16'h0002, 16'h270F};
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (4) @(negedge clk);
    // two-wire runs over analog, low, mid, high
    for (int k = 0; k < 4; k++) begin
      step(8'h0F, 8'(1 << k) & 8'h0E);
      note(6'h0A, spd[k ? 4 - k : 0]);
      step(8'h10, 8'h10);
      note(6'h01, 16'h0000);
      note(6'h00, 16'h0000);
      step(8'h10, 8'h00);
    end
    // reverse, then both closed
    note(6'h0E, spd[0]);
    step(8'h2F, 8'h20);
    note(6'h01, 16'h0000);
    note(6'h00, 16'h0000);
    step(8'h10, 8'h10);
    step(8'h30, 8'h00);
    // illegal codes on a general terminal
    note(6'h20, 16'h0000);
    setsel(16'h270F);
    setsel(16'h0004);
    note(6'h00, 16'h0000);
    setsel(16'h0019);
    // jog run ignores hold-release
    step(8'h40, 8'h40);
    note(6'h0A, spd[4]);
    step(8'h10, 8'h10);
    step(8'h01, 8'h01);
    step(8'h01, 8'h00);
    note(6'h01, 16'h0000);
    note(6'h00, 16'h0000);
    step(8'h50, 8'h00);
    // self-holding run, reverse, inhibit, release
    note(6'h10, 16'h0000);
    step(8'h01, 8'h01);
    note(6'h1A, spd[0]);
    pls(8'h10);
    note(6'h1E, spd[0]);
    pls(8'h20);
    note(6'h1C, spd[0]);
    step(8'h80, 8'h80);
    note(6'h1E, spd[0]);
    step(8'h80, 8'h00);
    note(6'h01, 16'h0000);
    note(6'h00, 16'h0000);
    step(8'h01, 8'h00);
    // an expected change that never came is a mismatch too
    if (q.size() != 0) begin
      n_mismatch++;
      $display("unexpected pending notes: expected 0 seen %0d", q.size());
    end
    complete_run();
  end
endmodule

bind rscl_run_latch rscl_run_latch_chk i_rscl_run_latch_chk (
  .clk, .rst, .fwd_run_input, .rev_run_input, .assign_terminal, .inch_run_input,
  .output_inhibit, .term_sel_0, .run_cmd, .drive_enable, .decel_stop,
  .self_hold_mode, .config_error
);
